/* File: hw/asb_pkg.sv */
// package of encodings and constants for the alu, shift and branch subset
package asb_pkg;
	localparam int ASB_WIDTH = 16;
	localparam int ASB_ACC_WIDTH = 40;
	localparam int ASB_TAKEN_CYCLES = 4;
	localparam int ASB_NOT_TAKEN_CYCLES = 1;
	localparam logic [4:0] ASB_SHAMT_MASK = 5'h0f;
	// status flag positions
	localparam int ASB_FLAG_C = 0;
	localparam int ASB_FLAG_Z = 1;
	localparam int ASB_FLAG_OV = 2;
	localparam int ASB_FLAG_N = 3;
	localparam int ASB_FLAG_DC = 4;
	localparam int ASB_FLAG_OA = 5;
	localparam int ASB_FLAG_OB = 6;
	localparam int ASB_FLAG_SA = 7;
	localparam int ASB_FLAG_SB = 8;
	localparam int ASB_NFLAGS = 9;
	localparam logic [ASB_NFLAGS-1:0] ASB_FLAGS_RESET = 9'h000;
	localparam logic [ASB_ACC_WIDTH-1:0] ASB_ACC_RESET = 40'h0000000000;
	localparam logic [ASB_WIDTH-1:0] ASB_DATA_RESET = 16'h0000;
	typedef enum logic [2:0] {
		ASB_OP_NONE = 3'b000,
		ASB_OP_ADD_WITH_CARRY = 3'b001,
		ASB_OP_ACC_ADD = 3'b010,
		ASB_OP_ACC_ADD_REG = 3'b011,
		ASB_OP_SHIFT_ONE = 3'b100,
		ASB_OP_SHIFT_REG = 3'b101,
		ASB_OP_SHIFT_LIT = 3'b110,
		ASB_OP_BRANCH = 3'b111
	} asb_op_t;
	// operand pair of the add-with-carry form
	typedef enum logic [1:0] {
		ASB_SRC_FILE_DEFAULT_WORKING_REG = 2'b00,
		ASB_SRC_TEN_BIT_LITERAL_REG = 2'b01,
		ASB_SRC_REG_REG = 2'b10,
		ASB_SRC_REG_FIVE_BIT_LITERAL = 2'b11
	} asb_src_t;
	typedef enum logic [4:0] {
		ASB_CC_ALWAYS = 5'h00,
		ASB_CC_C = 5'h01,
		ASB_CC_NC = 5'h02,
		ASB_CC_N = 5'h03,
		ASB_CC_NN = 5'h04,
		ASB_CC_OV = 5'h05,
		ASB_CC_NOV = 5'h06,
		ASB_CC_Z = 5'h07,
		ASB_CC_NZ = 5'h08,
		ASB_CC_GE = 5'h09,
		ASB_CC_GT = 5'h0a,
		ASB_CC_LE = 5'h0b,
		ASB_CC_LT = 5'h0c,
		ASB_CC_GEU = 5'h0d,
		ASB_CC_GTU = 5'h0e,
		ASB_CC_LEU = 5'h0f,
		ASB_CC_LTU = 5'h10,
		ASB_CC_OA = 5'h11,
		ASB_CC_OB = 5'h12,
		ASB_CC_SA = 5'h13,
		ASB_CC_SB = 5'h14
	} asb_cond_t;
	typedef enum logic [1:0] {
		ASB_ST_IDLE = 2'b00,
		ASB_ST_FLUSH = 2'b01
	} asb_state_t;
endpackage : asb_pkg

/* File: hw/asb_cond_eval.sv */
// branch condition evaluation from the status flags
`timescale 1ns/10ps
module asb_cond_eval (
	// selection
	input wire asb_pkg::asb_cond_t cond,
	input wire logic acc_present,
	// flags
	input wire logic [asb_pkg::ASB_NFLAGS-1:0] flags,
	// result
	output logic taken
);
	import asb_pkg::*;
	wire c = flags[ASB_FLAG_C];
	wire z = flags[ASB_FLAG_Z];
	wire v = flags[ASB_FLAG_OV];
	wire n = flags[ASB_FLAG_N];
	wire lt_signed = n ^ v;
	always_comb begin
		taken = 1'b0;
		unique case (cond)
			ASB_CC_ALWAYS: taken = 1'b1;
			ASB_CC_C: taken = c;
			ASB_CC_NC: taken = ~c;
			ASB_CC_N: taken = n;
			ASB_CC_NN: taken = ~n;
			ASB_CC_OV: taken = v;
			ASB_CC_NOV: taken = ~v;
			ASB_CC_Z: taken = z;
			ASB_CC_NZ: taken = ~z;
			ASB_CC_GE: taken = ~lt_signed;
			ASB_CC_GT: taken = ~lt_signed & ~z;
			ASB_CC_LE: taken = lt_signed | z;
			ASB_CC_LT: taken = lt_signed;
			ASB_CC_GEU: taken = c;
			ASB_CC_GTU: taken = c & ~z;
			ASB_CC_LEU: taken = ~c | z;
			ASB_CC_LTU: taken = ~c;
			ASB_CC_OA: taken = acc_present & flags[ASB_FLAG_OA];
			ASB_CC_OB: taken = acc_present & flags[ASB_FLAG_OB];
			ASB_CC_SA: taken = acc_present & flags[ASB_FLAG_SA];
			ASB_CC_SB: taken = acc_present & flags[ASB_FLAG_SB];
			default: taken = 1'b0;
		endcase
	end
endmodule : asb_cond_eval

/* File: hw/asb_datapath.sv */
// execution datapath: add with carry, accumulator add, arithmetic shifts, branches
`timescale 1ns/10ps
module asb_datapath #(
	parameter bit ACC_PRESENT = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// issue
	input wire logic issue_valid,
	input wire asb_pkg::asb_op_t issue_op,
	input wire asb_pkg::asb_src_t add_src,
	input wire logic to_working_reg,
	input wire logic acc_sel_b,
	input wire asb_pkg::asb_cond_t branch_cond,
	// operands
	input wire logic [asb_pkg::ASB_WIDTH-1:0] file_operand,
	input wire logic [asb_pkg::ASB_WIDTH-1:0] default_working_reg,
	input wire logic [asb_pkg::ASB_WIDTH-1:0] base_operand,
	input wire logic [asb_pkg::ASB_WIDTH-1:0] source_operand,
	input wire logic [9:0] ten_bit_literal,
	input wire logic [4:0] five_bit_literal,
	// answer
	output logic issue_ready,
	output logic result_valid,
	output logic [asb_pkg::ASB_WIDTH-1:0] result_data,
	output logic result_to_file,
	output logic result_to_working,
	output logic result_to_dest,
	output logic branch_taken,
	output logic [asb_pkg::ASB_NFLAGS-1:0] status_flags,
	output logic [asb_pkg::ASB_ACC_WIDTH-1:0] acc_a,
	output logic [asb_pkg::ASB_ACC_WIDTH-1:0] acc_b
);
	import asb_pkg::*;
	localparam logic [1:0] FLUSH_LEN = 2'(ASB_TAKEN_CYCLES - ASB_NOT_TAKEN_CYCLES - 1);
	asb_state_t state_reg, state_next;
	logic [1:0] flush_cnt_reg, flush_cnt_next;
	logic [ASB_NFLAGS-1:0] flags_reg, flags_next;
	logic [ASB_ACC_WIDTH-1:0] acc_a_reg, acc_b_reg;
	logic [ASB_WIDTH-1:0] data_reg;
	logic valid_reg, to_file_reg, to_work_reg, to_dest_reg, taken_reg;
	logic cond_true;
	wire go = issue_valid & issue_ready;
	// add operand selection
	wire is_file_form = add_src == ASB_SRC_FILE_DEFAULT_WORKING_REG;
	wire [ASB_WIDTH-1:0] add_a = is_file_form ? file_operand :
		(add_src == ASB_SRC_TEN_BIT_LITERAL_REG) ? {6'h00, ten_bit_literal} : base_operand;
	wire [ASB_WIDTH-1:0] add_b = is_file_form ? default_working_reg :
		(add_src == ASB_SRC_REG_FIVE_BIT_LITERAL) ? {11'h000, five_bit_literal} :
		(add_src == ASB_SRC_TEN_BIT_LITERAL_REG) ? base_operand : source_operand;
	wire cin = flags_reg[ASB_FLAG_C];
	wire [ASB_WIDTH:0] sum = {1'b0, add_a} + {1'b0, add_b} + {16'h0000, cin};
	wire [4:0] nib = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, cin};
	wire sum_ov = (add_a[15] == add_b[15]) & (sum[15] != add_a[15]);
	wire [ASB_WIDTH-1:0] sh_src = is_file_form ? file_operand : source_operand;
	wire [ASB_WIDTH-1:0] sh1 = {sh_src[15], sh_src[15:1]};
	wire [4:0] shamt = (issue_op == ASB_OP_SHIFT_REG) ? (source_operand[4:0] & ASB_SHAMT_MASK)
		: (five_bit_literal & ASB_SHAMT_MASK);
	wire [ASB_WIDTH-1:0] shn = 16'($signed(base_operand) >>> shamt);
	wire [ASB_ACC_WIDTH-1:0] acc_dst = acc_sel_b ? acc_b_reg : acc_a_reg;
	wire [ASB_ACC_WIDTH-1:0] acc_src = (issue_op == ASB_OP_ACC_ADD) ?
		(acc_sel_b ? acc_a_reg : acc_b_reg) : {{24{source_operand[15]}}, source_operand};
	wire [ASB_ACC_WIDTH:0] acc_sum = {acc_dst[39], acc_dst} + {acc_src[39], acc_src};
	wire acc_ov = acc_sum[40] != acc_sum[39];
	wire acc_ov31 = (acc_sum[39:31] != 9'h000) & (acc_sum[39:31] != 9'h1ff);
	wire acc_sat = acc_ov;
	wire [ASB_ACC_WIDTH-1:0] acc_res = acc_sat ?
		(acc_sum[40] ? 40'h8000000000 : 40'h7fffffffff) : acc_sum[39:0];
	wire do_acc = go & ACC_PRESENT &
		((issue_op == ASB_OP_ACC_ADD) | (issue_op == ASB_OP_ACC_ADD_REG));
	asb_cond_eval u_cond (
		.cond(branch_cond),
		.acc_present(ACC_PRESENT),
		.flags(flags_reg),
		.taken(cond_true)
	);
	assign issue_ready = state_reg == ASB_ST_IDLE;
	always_comb begin
		flags_next = flags_reg;
		if (go) begin
			unique case (issue_op)
				ASB_OP_ADD_WITH_CARRY: begin
					flags_next[ASB_FLAG_C] = sum[16];
					flags_next[ASB_FLAG_DC] = nib[4];
					flags_next[ASB_FLAG_N] = sum[15];
					flags_next[ASB_FLAG_OV] = sum_ov;
					flags_next[ASB_FLAG_Z] = sum[15:0] == 16'h0000;
				end
				ASB_OP_ACC_ADD, ASB_OP_ACC_ADD_REG: begin
					if (ACC_PRESENT) begin
						if (acc_sel_b) begin
							flags_next[ASB_FLAG_OB] = acc_ov31;
							flags_next[ASB_FLAG_SB] = flags_reg[ASB_FLAG_SB] | acc_sat;
						end else begin
							flags_next[ASB_FLAG_OA] = acc_ov31;
							flags_next[ASB_FLAG_SA] = flags_reg[ASB_FLAG_SA] | acc_sat;
						end
					end
				end
				ASB_OP_SHIFT_ONE: begin
					flags_next[ASB_FLAG_C] = sh_src[0];
					flags_next[ASB_FLAG_N] = sh1[15];
					flags_next[ASB_FLAG_OV] = 1'b0;
					flags_next[ASB_FLAG_Z] = sh1 == 16'h0000;
				end
				ASB_OP_SHIFT_REG, ASB_OP_SHIFT_LIT: begin
					flags_next[ASB_FLAG_N] = shn[15];
					flags_next[ASB_FLAG_Z] = shn == 16'h0000;
				end
				ASB_OP_BRANCH, ASB_OP_NONE: flags_next = flags_reg;
			endcase
		end
	end
	always_comb begin
		state_next = state_reg;
		flush_cnt_next = flush_cnt_reg;
		unique case (state_reg)
			ASB_ST_IDLE: begin
				if (go && issue_op == ASB_OP_BRANCH && cond_true) begin
					state_next = ASB_ST_FLUSH;
					flush_cnt_next = FLUSH_LEN;
				end
			end
			ASB_ST_FLUSH: begin
				if (flush_cnt_reg == 2'h0) begin
					state_next = ASB_ST_IDLE;
				end else begin
					flush_cnt_next = flush_cnt_reg - 2'h1;
				end
			end
			default: state_next = ASB_ST_IDLE;
		endcase
	end
	logic [ASB_WIDTH-1:0] data_next;
	logic wr_file, wr_work, wr_dest;
	always_comb begin
		data_next = ASB_DATA_RESET;
		wr_file = 1'b0;
		wr_work = 1'b0;
		wr_dest = 1'b0;
		unique case (issue_op)
			ASB_OP_ADD_WITH_CARRY: begin
				data_next = sum[15:0];
				wr_file = is_file_form & ~to_working_reg;
				wr_work = is_file_form & to_working_reg;
				wr_dest = ~is_file_form;
			end
			ASB_OP_SHIFT_ONE: begin
				data_next = sh1;
				wr_file = is_file_form & ~to_working_reg;
				wr_work = is_file_form & to_working_reg;
				wr_dest = ~is_file_form;
			end
			ASB_OP_SHIFT_REG, ASB_OP_SHIFT_LIT: begin
				data_next = shn;
				wr_dest = 1'b1;
			end
			ASB_OP_ACC_ADD, ASB_OP_ACC_ADD_REG, ASB_OP_BRANCH, ASB_OP_NONE: begin
				data_next = ASB_DATA_RESET;
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ASB_ST_IDLE;
			flush_cnt_reg <= 2'h0;
			flags_reg <= ASB_FLAGS_RESET;
		end else begin
			state_reg <= state_next;
			flush_cnt_reg <= flush_cnt_next;
			flags_reg <= flags_next;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_a_reg <= ASB_ACC_RESET;
			acc_b_reg <= ASB_ACC_RESET;
		end else if (do_acc) begin
			if (acc_sel_b) begin
				acc_b_reg <= acc_res;
			end else begin
				acc_a_reg <= acc_res;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			valid_reg <= 1'b0;
			data_reg <= ASB_DATA_RESET;
			to_file_reg <= 1'b0;
			to_work_reg <= 1'b0;
			to_dest_reg <= 1'b0;
			taken_reg <= 1'b0;
		end else begin
			valid_reg <= go;
			data_reg <= go ? data_next : data_reg;
			to_file_reg <= go & wr_file;
			to_work_reg <= go & wr_work;
			to_dest_reg <= go & wr_dest;
			taken_reg <= go & (issue_op == ASB_OP_BRANCH) & cond_true;
		end
	end
	assign result_valid = valid_reg;
	assign result_data = data_reg;
	assign result_to_file = to_file_reg;
	assign result_to_working = to_work_reg;
	assign result_to_dest = to_dest_reg;
	assign branch_taken = taken_reg;
	assign status_flags = flags_reg;
	assign acc_a = acc_a_reg;
	assign acc_b = acc_b_reg;
endmodule : asb_datapath

/* File: tb/asb_datapath_properties.sv */
// assertions on the datapath top ports
`timescale 1ns/10ps
module asb_datapath_properties (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// issue
	input wire logic issue_valid,
	input wire asb_pkg::asb_op_t issue_op,
	// answer
	input wire logic issue_ready,
	input wire logic result_valid,
	input wire logic [asb_pkg::ASB_WIDTH-1:0] result_data,
	input wire logic branch_taken,
	input wire logic [asb_pkg::ASB_NFLAGS-1:0] status_flags
);
	import asb_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire logic acc_w = issue_valid && issue_ready;
	wire logic shn_w = acc_w && (issue_op == ASB_OP_SHIFT_REG || issue_op == ASB_OP_SHIFT_LIT);
	AST_ANSWER_ONE: assert property (acc_w && issue_op != ASB_OP_NONE |=> result_valid)
		else $error("no result one cycle after issue");
	AST_TAKEN_STALL: assert property (result_valid && branch_taken |->
		!issue_ready [*3] ##1 issue_ready) else $error("taken branch not four cycles");
	AST_NOT_TAKEN_FREE: assert property (acc_w && issue_op == ASB_OP_BRANCH |=>
		issue_ready != branch_taken) else $error("branch ready mismatch");
	AST_BRANCH_FLAGS: assert property (acc_w && issue_op == ASB_OP_BRANCH |=>
		$stable(status_flags)) else $error("branch changed flags");
	AST_SHIFT_NZ_ONLY: assert property (shn_w |=>
		(status_flags & 9'h1f5) == ($past(status_flags) & 9'h1f5)) else $error("shift flags");
	AST_SHIFT_NZ_VALUE: assert property (shn_w |=> status_flags[ASB_FLAG_N] == result_data[15]
		&& status_flags[ASB_FLAG_Z] == (result_data == 16'h0000)) else $error("shift n z");
	AST_ACC_KEEPS_ALU: assert property (acc_w && (issue_op == ASB_OP_ACC_ADD
		|| issue_op == ASB_OP_ACC_ADD_REG) |=> $stable(status_flags[4:0])) else $error("acc flags");
	AST_ADD_KEEPS_ACC: assert property (acc_w && issue_op == ASB_OP_ADD_WITH_CARRY |=>
		$stable(status_flags[8:5])) else $error("add touched acc flags");
	AST_SHIFT_ONE_KEEPS: assert property (acc_w && issue_op == ASB_OP_SHIFT_ONE |=>
		$stable(status_flags[8:4])) else $error("shift touched other flags");
endmodule : asb_datapath_properties
bind asb_datapath asb_datapath_properties chk_u (.clk(clk), .rst(rst),
	.issue_valid(issue_valid), .issue_op(issue_op), .issue_ready(issue_ready),
	.result_valid(result_valid), .result_data(result_data),
	.branch_taken(branch_taken), .status_flags(status_flags));

/* File: tb/asb_issue_model.sv */
// issue-side model offering instructions to the datapath
`timescale 1ns/10ps
module asb_issue_model (
	// clock
	input wire logic clk,
	// issue
	output logic issue_valid,
	output asb_pkg::asb_op_t issue_op,
	output asb_pkg::asb_src_t add_src,
	output logic to_working_reg,
	output logic acc_sel_b,
	output asb_pkg::asb_cond_t branch_cond,
	output logic [15:0] opa,
	output logic [15:0] opb,
	// answer
	input wire logic issue_ready
);
	import asb_pkg::*;
	bit hung;
	initial begin
		issue_valid = 1'b0;
		issue_op = ASB_OP_NONE;
		add_src = ASB_SRC_FILE_DEFAULT_WORKING_REG;
		to_working_reg = 1'b0;
		acc_sel_b = 1'b0;
		branch_cond = ASB_CC_ALWAYS;
		opa = 16'h0000;
		opb = 16'h0000;
	end
	// offer held until an edge sees ready
	task automatic send(input asb_op_t op, input asb_src_t src, input asb_cond_t cc,
			input logic tw, input logic [15:0] a, input logic [15:0] b);
		int n;
		issue_valid = 1'b1;
		issue_op = op;
		add_src = src;
		branch_cond = cc;
		to_working_reg = tw;
		opa = a;
		opb = b;
		for (n = 0; n < 8 && !issue_ready; n++) begin
			@(posedge clk);
			#1;
		end
		hung = !issue_ready;
		@(posedge clk);
		#1;
	endtask : send
	// withdraw the offer and let one edge pass before the next one
	task automatic stop;
		issue_valid = 1'b0;
		@(posedge clk);
		#1;
	endtask : stop
	task automatic pick_acc(input logic b);
		acc_sel_b = b;
	endtask : pick_acc
endmodule : asb_issue_model

/* File: tb/alu_shift_branch_subset_test.sv */
// self-checking bench for the alu, shift and branch datapath
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module alu_shift_branch_subset_test;
	import asb_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	int err_count = 0;
	int n_compared = 0;
	logic issue_valid, to_working_reg, acc_sel_b, issue_ready, result_valid;
	logic result_to_file, result_to_working, result_to_dest, branch_taken;
	asb_op_t issue_op;
	asb_src_t add_src;
	asb_cond_t branch_cond;
	logic [15:0] opa, opb, result_data;
	logic [ASB_NFLAGS-1:0] status_flags;
	logic [ASB_ACC_WIDTH-1:0] acc_a, acc_b;
	initial forever #12.5 clk = ~clk;
	asb_datapath dut_u (.clk, .rst, .issue_valid, .issue_op, .add_src, .to_working_reg,
		.acc_sel_b, .branch_cond, .file_operand(opa), .default_working_reg(opb),
		.base_operand(opa), .source_operand(opb), .ten_bit_literal(opb[9:0]),
		.five_bit_literal(opb[4:0]), .issue_ready, .result_valid, .result_data,
		.result_to_file, .result_to_working, .result_to_dest, .branch_taken,
		.status_flags, .acc_a, .acc_b);
	asb_issue_model p_u (.clk, .issue_valid, .issue_op, .add_src, .to_working_reg,
		.acc_sel_b, .branch_cond, .opa, .opb, .issue_ready);
	task automatic test_done;
		if (err_count == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	task automatic run(input asb_op_t op, input asb_cond_t cc, input logic tw,
			input logic [15:0] a, input logic [15:0] b, input asb_src_t src);
		p_u.send(op, src, cc, tw, a, b);
		if (p_u.hung) begin
			err_count++;
			test_done();
		end
	endtask : run
	task automatic check_reset;
		`CHK("ready", 1'b1, issue_ready)
		`CHK("flags", 9'h000, status_flags)
		`CHK("valid", 1'b0, result_valid)
		`CHK("acc_a", 40'h0000000000, acc_a)
		`CHK("acc_b", 40'h0000000000, acc_b)
	endtask : check_reset
	task automatic check_alu;
		asb_op_t op[8] = '{ASB_OP_ADD_WITH_CARRY, ASB_OP_ADD_WITH_CARRY, ASB_OP_ADD_WITH_CARRY,
			ASB_OP_ADD_WITH_CARRY, ASB_OP_SHIFT_ONE, ASB_OP_SHIFT_ONE, ASB_OP_SHIFT_LIT,
			ASB_OP_SHIFT_REG};
		asb_src_t src[8] = '{ASB_SRC_FILE_DEFAULT_WORKING_REG, ASB_SRC_REG_REG, ASB_SRC_REG_FIVE_BIT_LITERAL,
			ASB_SRC_TEN_BIT_LITERAL_REG, ASB_SRC_FILE_DEFAULT_WORKING_REG, ASB_SRC_FILE_DEFAULT_WORKING_REG, ASB_SRC_FILE_DEFAULT_WORKING_REG,
			ASB_SRC_FILE_DEFAULT_WORKING_REG};
		logic tw[8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
		logic [15:0] a[8] = '{16'h7fff, 16'hffff, 16'h0003, 16'h0001, 16'h0002, 16'h8003,
			16'h8000, 16'h4000};
		logic [15:0] b[8] = '{16'h0001, 16'h0002, 16'h0004, 16'h0001, 16'h0000, 16'h0000,
			16'h0004, 16'h000e};
		logic [15:0] r[8] = '{16'h8000, 16'h0001, 16'h0008, 16'h0002, 16'h0001, 16'hc001,
			16'hf800, 16'h0001};
		logic [8:0] f[8] = '{9'h01c, 9'h011, 9'h000, 9'h000, 9'h000, 9'h009, 9'h009, 9'h001};
		logic [7:0] fl = 8'h20;
		logic [7:0] dl = 8'hce;
		for (int i = 0; i < 8; i++) begin
			run(op[i], ASB_CC_ALWAYS, tw[i], a[i], b[i], src[i]);
			`CHK("valid", 1'b1, result_valid)
			`CHK("data", r[i], result_data)
			`CHK("flags", f[i], status_flags)
			`CHK("to_work", tw[i], result_to_working)
			`CHK("to_file", fl[i], result_to_file)
			`CHK("to_dest", dl[i], result_to_dest)
		end
		p_u.stop();
	endtask : check_alu
	task automatic check_acc;
		run(ASB_OP_ACC_ADD_REG, ASB_CC_ALWAYS, 1'b0, 16'h0000, 16'h8000, ASB_SRC_FILE_DEFAULT_WORKING_REG);
		p_u.stop();
		`CHK("acc_a", 40'hffffff8000, acc_a)
		`CHK("flags", 9'h001, status_flags)
		// fibonacci growth drives both accumulators into saturation
		for (int j = 1; j <= 37; j++) begin
			p_u.pick_acc(j[0]);
			run(ASB_OP_ACC_ADD, ASB_CC_ALWAYS, 1'b0, 16'h0000, 16'h0000, ASB_SRC_FILE_DEFAULT_WORKING_REG);
		end
		p_u.pick_acc(1'b0);
		p_u.stop();
		`CHK("acc_a", 40'h8000000000, acc_a)
		`CHK("acc_b", 40'h8000000000, acc_b)
		`CHK("flags", 9'h1e1, status_flags)
	endtask : check_acc
	task automatic check_branch(input logic [8:0] fl, input logic [20:0] exp_taken);
		for (int i = 0; i < 21; i++) begin
			run(ASB_OP_BRANCH, asb_cond_t'(i[4:0]), 1'b0, 16'h0000, 16'h0000, ASB_SRC_FILE_DEFAULT_WORKING_REG);
			`CHK("taken", exp_taken[i], branch_taken)
			`CHK("ready", !exp_taken[i], issue_ready)
			`CHK("flags", fl, status_flags)
		end
	endtask : check_branch
	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		check_reset();
		check_alu();
		check_branch(9'h001, 21'h006753);
		check_acc();
		check_branch(9'h1e1, 21'h1e6753);
		p_u.stop();
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		check_reset();
		test_done();
	end
endmodule : alu_shift_branch_subset_test
